/* File: verilog/ddc_output_order_nco_config.sv */
// Purpose: AHB-Lite register bank for DDC output ordering and tuning, with the ordering datapath
// Assumes: Input samples arrive on hclk, at least two cycles apart in complex mode
// Notes: Reads take one wait state, writes none; response is always OKAY
`timescale 1ns/1ns
`include "ddc_order_regs.svh"

module ddc_output_order_nco_config (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ddc_order_pkg::iq_sample_t sample_chan_a,
    input wire ddc_order_pkg::iq_sample_t sample_chan_b,
    output ddc_order_pkg::lane_word_t serial_cmos_output_chan_a,
    output ddc_order_pkg::lane_word_t serial_cmos_output_chan_b,
    output logic [31:0] nco_phase_chan_a
);
    import ddc_order_pkg::*;

    logic [7:0] dec_mode_ctrl_reg;
    logic [7:0] mixer_ctrl_reg;
    logic [7:0] chan_a_output_order_ctrl_reg;
    logic [7:0] chan_b_output_order_ctrl_reg;
    // Bytes 0..3 of the channel A tuning word
    logic [7:0] tuning_word_chan_a_reg [4];
    logic [31:0] tuning_word_chan_a;
    logic [31:0] active_word_reg;
    logic [31:0] phase_reg;
    logic reload_seen_reg;
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic rd_pend_reg;
    logic [7:0] rd_idx_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic addr_ok;
    logic real_mode;
    logic [2:0] dec_code;
    chan_cfg_t cfg [2];
    iq_sample_t samp_in [2];
    lane_word_t lane_reg [2];

    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    // Keep-one-in-N mask; unused codes fall back to bypass
    function automatic logic [4:0] dec_mask(input logic [2:0] code);
        case (code)
            3'h1: dec_mask = 5'h01;
            3'h2: dec_mask = 5'h03;
            3'h3: dec_mask = 5'h07;
            3'h4: dec_mask = 5'h0f;
            3'h5: dec_mask = 5'h1f;
            default: dec_mask = 5'h00;
        endcase
    endfunction

    // Multiply by a quarter-rate complex tone; invert runs the tone the other way
    function automatic iq_t quarter_rotate(input iq_t x, input logic [1:0] step, input logic inv);
        iq_t y;
        y = x;
        case (step)
            2'h0: y = x;
            2'h1: begin
                y.i = inv ? -x.q : x.q;
                y.q = inv ? x.i : -x.i;
            end
            2'h2: begin
                y.i = -x.i;
                y.q = -x.q;
            end
            2'h3: begin
                y.i = inv ? x.q : -x.q;
                y.q = inv ? -x.i : x.i;
            end
            default: y = x;
        endcase
        quarter_rotate = y;
    endfunction

    assign real_mode = dec_mode_ctrl_reg[`REAL_OUT_BIT];
    assign dec_code = dec_mode_ctrl_reg[`DEC_FIELD_MSB:`DEC_FIELD_LSB];
    assign tuning_word_chan_a = {tuning_word_chan_a_reg[3], tuning_word_chan_a_reg[2],
                                 tuning_word_chan_a_reg[1], tuning_word_chan_a_reg[0]};
    assign addr_ok = hsel && hready && htrans[1];

    assign cfg[0].swap_iq = chan_a_output_order_ctrl_reg[`SWAP_IQ_BIT];
    assign cfg[0].quad_delay = chan_a_output_order_ctrl_reg[`QUAD_DELAY_BIT];
    assign cfg[0].quarter_invert = chan_a_output_order_ctrl_reg[`QUARTER_INVERT_BIT];
    assign cfg[0].quarter_enable = mixer_ctrl_reg[`QUARTER_EN_A_BIT];
    assign cfg[1].swap_iq = chan_b_output_order_ctrl_reg[`SWAP_IQ_BIT];
    assign cfg[1].quad_delay = chan_b_output_order_ctrl_reg[`QUAD_DELAY_BIT];
    assign cfg[1].quarter_invert = chan_b_output_order_ctrl_reg[`QUARTER_INVERT_BIT];
    assign cfg[1].quarter_enable = mixer_ctrl_reg[`QUARTER_EN_B_BIT];
    assign samp_in[0] = sample_chan_a;
    assign samp_in[1] = sample_chan_b;

    // Bus address phase: writes land next cycle, reads answer one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            rd_pend_reg <= 1'b0;
            rd_idx_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            hreadyout_reg <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                wr_idx_reg <= reg_index(haddr);
                rd_idx_reg <= reg_index(haddr);
            end
        end
    end

    // Waiting one cycle lets a read right after a write see the stored value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            case (rd_idx_reg)
                `IDX_DEC_MODE: hrdata_reg <= {24'h00_0000, dec_mode_ctrl_reg};
                `IDX_MIX_CTRL: hrdata_reg <= {24'h00_0000, mixer_ctrl_reg};
                `IDX_ORDER_A: hrdata_reg <= {24'h00_0000, chan_a_output_order_ctrl_reg};
                `IDX_TUNE_A0: hrdata_reg <= {24'h00_0000, tuning_word_chan_a_reg[0]};
                `IDX_TUNE_A1: hrdata_reg <= {24'h00_0000, tuning_word_chan_a_reg[1]};
                `IDX_TUNE_A2: hrdata_reg <= {24'h00_0000, tuning_word_chan_a_reg[2]};
                `IDX_TUNE_A3: hrdata_reg <= {24'h00_0000, tuning_word_chan_a_reg[3]};
                `IDX_ORDER_B: hrdata_reg <= {24'h00_0000, chan_b_output_order_ctrl_reg};
                `IDX_NCO_STATUS: hrdata_reg <= phase_reg;
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Reserved bits are stored as written; software keeps them zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_mode_ctrl_reg <= `CTRL_RESET;
            mixer_ctrl_reg <= `CTRL_RESET;
            chan_a_output_order_ctrl_reg <= `CTRL_RESET;
            chan_b_output_order_ctrl_reg <= `CTRL_RESET;
        end else if (wr_pend_reg) begin
            case (wr_idx_reg)
                `IDX_DEC_MODE: dec_mode_ctrl_reg <= hwdata[7:0];
                `IDX_MIX_CTRL: mixer_ctrl_reg <= hwdata[7:0];
                `IDX_ORDER_A: chan_a_output_order_ctrl_reg <= hwdata[7:0];
                `IDX_ORDER_B: chan_b_output_order_ctrl_reg <= hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Tuning bytes: held at zero for as long as real decimation is selected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < 4; k++) begin
                tuning_word_chan_a_reg[k] <= `TUNE_RESET;
            end
        end else if (real_mode) begin
            for (int k = 0; k < 4; k++) begin
                tuning_word_chan_a_reg[k] <= `TUNE_RESET;
            end
        end else if (wr_pend_reg) begin
            case (wr_idx_reg)
                `IDX_TUNE_A0: tuning_word_chan_a_reg[0] <= hwdata[7:0];
                `IDX_TUNE_A1: tuning_word_chan_a_reg[1] <= hwdata[7:0];
                `IDX_TUNE_A2: tuning_word_chan_a_reg[2] <= hwdata[7:0];
                `IDX_TUNE_A3: tuning_word_chan_a_reg[3] <= hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Oscillator: the written word only takes effect on a reload toggle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_seen_reg <= 1'b0;
            active_word_reg <= `PHASE_RESET;
            phase_reg <= `PHASE_RESET;
        end else begin
            reload_seen_reg <= mixer_ctrl_reg[`RELOAD_A_BIT];
            if (reload_seen_reg != mixer_ctrl_reg[`RELOAD_A_BIT]) begin
                phase_reg <= `PHASE_RESET;
                active_word_reg <= tuning_word_chan_a;
            end else if (real_mode) begin
                phase_reg <= `PHASE_RESET;
            end else if (samp_in[0].valid) begin
                phase_reg <= phase_reg + active_word_reg;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [4:0] dec_cnt_reg;
            logic [1:0] rot_reg;
            logic pend_reg;
            lane_word_t second_reg;
            iq_t held_reg;
            iq_t mixed;
            iq_t pair;
            logic keep;

            // Quarter-rate mixing is a complex operation, so real mode skips it
            always_comb begin
                mixed = samp_in[ch].data;
                if (cfg[ch].quarter_enable && !real_mode) begin
                    mixed = quarter_rotate(samp_in[ch].data, rot_reg,
                                           cfg[ch].quarter_invert);
                end
                keep = samp_in[ch].valid && (dec_cnt_reg == 5'h00);
                pair.q = mixed.q;
                // Q of this sample pairs with I of the kept sample before
                pair.i = cfg[ch].quad_delay ? held_reg.i : mixed.i;
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dec_cnt_reg <= 5'h00;
                    rot_reg <= 2'h0;
                    held_reg <= '0;
                end else if (samp_in[ch].valid) begin
                    dec_cnt_reg <= (dec_cnt_reg + 5'h01) & dec_mask(dec_code);
                    rot_reg <= rot_reg + 2'h1;
                    if (keep) begin
                        held_reg <= mixed;
                    end
                end
            end

            // A new sample overwrites a pending second word; input spacing prevents it
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lane_reg[ch] <= '0;
                    second_reg <= '0;
                    pend_reg <= 1'b0;
                end else begin
                    lane_reg[ch].valid <= 1'b0;
                    if (pend_reg) begin
                        lane_reg[ch] <= second_reg;
                        pend_reg <= 1'b0;
                    end
                    if (keep && real_mode) begin
                        // Order and delay bits are ignored here
                        lane_reg[ch] <= '{valid: 1'b1, is_q: 1'b0, data: mixed.i};
                    end else if (keep && cfg[ch].swap_iq) begin
                        lane_reg[ch] <= '{valid: 1'b1, is_q: 1'b1, data: pair.q};
                        second_reg <= '{valid: 1'b1, is_q: 1'b0, data: pair.i};
                        pend_reg <= 1'b1;
                    end else if (keep) begin
                        lane_reg[ch] <= '{valid: 1'b1, is_q: 1'b0, data: pair.i};
                        second_reg <= '{valid: 1'b1, is_q: 1'b1, data: pair.q};
                        pend_reg <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign serial_cmos_output_chan_a = lane_reg[0];
    assign serial_cmos_output_chan_b = lane_reg[1];
    assign nco_phase_chan_a = phase_reg;

endmodule

/* File: verilog/ddc_order_regs.svh */
// Purpose: Offsets, field positions, reset values for the DDC ordering and tuning registers
// Assumes: Offsets are word indices; byte address is four times the index
// Notes: Included by the register bank only
`ifndef DDC_ORDER_REGS_SVH
`define DDC_ORDER_REGS_SVH

`define IDX_DEC_MODE 8'h25
`define IDX_MIX_CTRL 8'h26
`define IDX_ORDER_A 8'h27
`define IDX_TUNE_A0 8'h2a
`define IDX_TUNE_A1 8'h2b
`define IDX_TUNE_A2 8'h2c
`define IDX_TUNE_A3 8'h2d
`define IDX_ORDER_B 8'h2e
`define IDX_NCO_STATUS 8'h30

`define SWAP_IQ_BIT 4
`define QUAD_DELAY_BIT 3
`define QUARTER_INVERT_BIT 2
`define DEC_FIELD_MSB 6
`define DEC_FIELD_LSB 4
`define REAL_OUT_BIT 3
`define RELOAD_A_BIT 5
`define QUARTER_EN_A_BIT 4
`define QUARTER_EN_B_BIT 0

`define CTRL_RESET 8'h00
`define TUNE_RESET 8'h00
`define PHASE_RESET 32'h0000_0000

`endif

/* File: verilog/ddc_order_pkg.sv */
// Purpose: Types shared by the DDC ordering block and its bench
// Assumes: 14-bit signed samples
// Notes: Constants live in ddc_order_regs.svh
package ddc_order_pkg;

    typedef struct packed {
        logic signed [13:0] i;
        logic signed [13:0] q;
    } iq_t;

    typedef struct packed {
        logic valid;
        iq_t data;
    } iq_sample_t;

    typedef struct packed {
        logic valid;
        logic is_q;
        logic [13:0] data;
    } lane_word_t;

    typedef struct packed {
        logic swap_iq;
        logic quad_delay;
        logic quarter_invert;
        logic quarter_enable;
    } chan_cfg_t;

endpackage

/* File: test/ddc_order_chk.sv */
// Purpose: Port checks for the DDC ordering bank
// Assumes: Samples reach the block at least two cycles apart
// Notes: Bound onto the bank after the module
`timescale 1ns/1ns
module ddc_order_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire ddc_order_pkg::iq_sample_t sample_chan_a,
    input wire ddc_order_pkg::iq_sample_t sample_chan_b,
    input wire ddc_order_pkg::lane_word_t serial_cmos_output_chan_a,
    input wire ddc_order_pkg::lane_word_t serial_cmos_output_chan_b,
    input wire logic [31:0] nco_phase_chan_a
);
    import ddc_order_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take, wr, sa, sb;
    lane_word_t la, lb;
    assign take = hsel && hready && htrans[1];
    assign wr = take && hwrite;
    assign sa = sample_chan_a.valid;
    assign sb = sample_chan_b.valid;
    assign la = serial_cmos_output_chan_a;
    assign lb = serial_cmos_output_chan_b;
    a_write_no_wait: assert property (wr |=> hreadyout)
        else $error("write stalled");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_lane_cause_a: assert property (la.valid |-> $past(sa) || $past(sa, 2))
        else $error("lane a word without sample");
    a_lane_cause_b: assert property (lb.valid |-> $past(sb) || $past(sb, 2))
        else $error("lane b word without sample");
    a_iq_alt_a: assert property (la.valid && $past(la.valid) |-> la.is_q != $past(la.is_q))
        else $error("lane a pair broken");
    a_iq_alt_b: assert property (lb.valid && $past(lb.valid) |-> lb.is_q != $past(lb.is_q))
        else $error("lane b pair broken");
    // Reload lands late, so writes up to four edges back count
    a_phase_cause: assert property ($changed(nco_phase_chan_a) |->
        $past(sa) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
        else $error("phase moved alone");
    c_read: cover property (take && !hwrite ##2 hreadyout);
    c_pair_a: cover property (la.valid ##1 la.valid);
    c_phase: cover property ($changed(nco_phase_chan_a));
endmodule
bind ddc_output_order_nco_config ddc_order_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .sample_chan_a, .sample_chan_b, .serial_cmos_output_chan_a, .serial_cmos_output_chan_b, .nco_phase_chan_a);

/* File: test/lane_rx_model.sv */
// Purpose: Receiving logic at the far end of one sample lane
// Assumes: Words are sampled on the rising edge
// Notes: Never stalls, since the lane has no back pressure
`timescale 1ns/1ns
module lane_rx_model (
    input wire logic hclk,
    input wire ddc_order_pkg::lane_word_t lane
);
    import ddc_order_pkg::*;
    lane_word_t words[$];
    always @(posedge hclk) begin
        if (lane.valid === 1'b1) begin
            words.push_back(lane);
        end
    end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the DDC ordering bank
// Assumes: One bus master, samples four cycles apart
// Notes: Lane words are collected by two receiver models
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("unexpected %s %h %h", n, e, g); \
    end \
end
module tb;
    import ddc_order_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, nco;
    logic [1:0] htrans = 0;
    iq_sample_t sa = '0, sb = '0;
    lane_word_t la, lb;
    int mismatches = 0, tests_run = 0;
    ddc_output_order_nco_config DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sample_chan_a(sa), .sample_chan_b(sb),
        .serial_cmos_output_chan_a(la), .serial_cmos_output_chan_b(lb), .nco_phase_chan_a(nco));
    lane_rx_model rxa (.hclk, .lane(la));
    lane_rx_model rxb (.hclk, .lane(lb));
    initial begin
        forever #2 hclk = ~hclk;
    end
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [31:0] r);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(idx, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] r;
        bus(idx, 1'b0, 8'h0, r);
        `CHK("register", e, r)
    endtask
    task automatic send(input bit ch, input logic [13:0] i, input logic [13:0] q);
        if (ch) sb <= '{1'b1, '{i, q}};
        else sa <= '{1'b1, '{i, q}};
        @(posedge hclk);
        sa.valid <= 1'b0;
        sb.valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    function automatic lane_word_t get_word(input bit ch);
        if (ch && rxb.words.size() > 0) return rxb.words.pop_front();
        if (!ch && rxa.words.size() > 0) return rxa.words.pop_front();
        return '0;
    endfunction
    // Popped once up front, so a mismatch report cannot pop a second word
    task automatic pop(input bit ch, input logic iq, input logic [13:0] d);
        lane_word_t w;
        w = get_word(ch);
        `CHK("lane word", {1'b1, iq, d}, w)
    endtask
    task automatic clr;
        rxa.words.delete();
        rxb.words.delete();
    endtask
    task automatic t_regs;
        logic [7:0] idx [6] = '{8'h27, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
        logic [7:0] val [6] = '{8'h1c, 8'h11, 8'h22, 8'h33, 8'h44, 8'h14};
        foreach (idx[k]) rd(idx[k], 32'h0);
        foreach (idx[k]) wr(idx[k], val[k]);
        foreach (idx[k]) rd(idx[k], {24'h0, val[k]});
        wr(8'h40, 8'h5a);
        rd(8'h40, 32'h0);
        foreach (idx[k]) wr(idx[k], 8'h00);
    endtask
    task automatic t_order;
        logic s, d;
        logic [13:0] iv;
        for (int ch = 0; ch < 2; ch++) begin
            for (int m = 0; m < 4; m++) begin
                {s, d} = 2'(m);
                iv = d ? 14'h0111 : 14'h0333;
                wr(ch ? 8'h2e : 8'h27, {3'h0, s, d, 3'h0});
                send(ch[0], 14'h0111, 14'h0222);
                clr();
                send(ch[0], 14'h0333, 14'h0444);
                pop(ch[0], s, s ? 14'h0444 : iv);
                pop(ch[0], !s, s ? iv : 14'h0444);
            end
            wr(ch ? 8'h2e : 8'h27, 8'h00);
        end
    endtask
    task automatic mix(input bit ch, input bit inv);
        logic [13:0] i1, q1;
        lane_word_t w;
        clr();
        send(ch, 14'h0100, 14'h0200);
        send(ch, 14'h0100, 14'h0200);
        w = get_word(ch);
        i1 = w.data;
        w = get_word(ch);
        q1 = w.data;
        // Rotation start is not visible, so judge the step between samples
        pop(ch, 1'b0, inv ? -q1 : q1);
        pop(ch, 1'b1, inv ? i1 : -i1);
    endtask
    task automatic t_mixer;
        wr(8'h26, 8'h11);
        for (int inv = 0; inv < 2; inv++) begin
            wr(8'h27, {5'h0, inv[0], 2'h0});
            wr(8'h2e, {5'h0, inv[0], 2'h0});
            mix(1'b0, inv[0]);
            mix(1'b1, inv[0]);
        end
        wr(8'h26, 8'h00);
        wr(8'h27, 8'h00);
        wr(8'h2e, 8'h00);
    endtask
    task automatic t_decim;
        for (int c = 1; c < 6; c++) begin
            wr(8'h25, {1'h0, 3'(c), 4'h0});
            clr();
            repeat (2 << c) send(1'b0, 14'h0010, 14'h0020);
            `CHK("kept words", 4, rxa.words.size())
        end
        wr(8'h25, 8'h00);
    endtask
    task automatic t_real;
        wr(8'h2a, 8'h55);
        wr(8'h25, 8'h08);
        rd(8'h2a, 32'h0);
        wr(8'h2b, 8'h66);
        rd(8'h2b, 32'h0);
        clr();
        send(1'b0, 14'h0123, 14'h0456);
        `CHK("real words", 1, rxa.words.size())
        pop(1'b0, 1'b0, 14'h0123);
        `CHK("real phase", 32'h0, nco)
        wr(8'h25, 8'h00);
    endtask
    task automatic t_nco;
        for (int k = 0; k < 4; k++) wr(8'h2a + 8'(k), 8'(k + 1));
        wr(8'h26, 8'h20);
        repeat (4) @(posedge hclk);
        send(1'b0, 14'h0001, 14'h0002);
        send(1'b0, 14'h0001, 14'h0002);
        rd(8'h30, 32'h0806_0402);
        wr(8'h2a, 8'h10);
        wr(8'h26, 8'h00);
        repeat (4) @(posedge hclk);
        `CHK("phase reload", 32'h0, nco)
        send(1'b0, 14'h0001, 14'h0002);
        `CHK("phase step", 32'h0403_0210, nco)
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_order();
        t_mixer();
        t_decim();
        t_real();
        t_nco();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        end_sim();
    end
endmodule
